/* bench/psrb_bank_asserts.sv */
// Purpose: Port checker for the power and status register bank.
// Assumes: Derived outputs follow a taken write two edges later.
// Notes:   Bound to every psrb_bank instance.
`timescale 1ns/1ps
`default_nettype none
module psrb_bank_asserts (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        ce,
  input wire logic [11:0] regAddr,
  input wire logic        regWr,
  input wire logic        regRd,
  input wire logic [7:0]  regWdata,
  input wire logic        regRvalid,
  input wire logic        softReset,
  input wire logic        serialOutputPinEnable,
  input wire logic        biasPowerDown,
  input wire logic [13:0] channelPowerDown,
  input wire logic [13:0] channelRegEnable,
  input wire logic [7:0]  monitorSelZero,
  input wire logic        statusPinZero,
  input wire logic        statusPinZeroOe
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_read_answers: assert property (ce && regRd |=> regRvalid)
    else $error("read gave no valid");
  a_no_stray_valid: assert property (regRvalid |-> $past(regRd))
    else $error("valid without read");
  a_soft_reset_and: assert property (ce && regWr && regAddr == 12'h000 |-> ##2
    softReset == ($past(regWdata[7], 2) & $past(regWdata[0], 2)))
    else $error("soft reset not anded");
  a_out_pin_and: assert property (ce && regWr && regAddr == 12'h000 |-> ##2
    serialOutputPinEnable == ($past(regWdata[4], 2) & $past(regWdata[3], 2)))
    else $error("output pin enable not anded");
  a_chan_pd_low: assert property (ce && regWr && regAddr == 12'h501 |-> ##2
    channelPowerDown[7:0] == $past(regWdata, 2))
    else $error("channel power-down wrong");
  a_mon_sel_zero: assert property (ce && regWr && regAddr == 12'h505 |-> ##2
    monitorSelZero == $past(regWdata, 2))
    else $error("monitor select wrong");
  a_pin_gated: assert property (!$past(statusPinZeroOe) && !statusPinZeroOe |-> !statusPinZero)
    else $error("status pin driven while disabled");
  a_reset_values: assert property ($rose(rst_n) |-> biasPowerDown && channelRegEnable == 14'h3FFF)
    else $error("reset values wrong");
endmodule
bind psrb_bank psrb_bank_asserts chk (.*);
`default_nettype wire

/* bench/psrb_host.sv */
// Purpose: Host side of the register port.
// Assumes: One request at a time, driven on the rising edge.
// Notes:   Idle address and data carry inverted values after a write; after a read only the address is inverted.
`timescale 1ns/1ps
`default_nettype none
module psrb_host (
  input  wire logic        clk,
  input  wire logic        regRvalid,
  input  wire logic [7:0]  regRdata,
  output var  logic        regWr,
  output var  logic        regRd,
  output var  logic [11:0] regAddr,
  output var  logic [7:0]  regWdata
);
  initial
  begin
    regWr = 1'b0;
    regRd = 1'b0;
    regAddr = 12'hFFF;
    regWdata = 8'h00;
  end
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk);
    regWr <= 1'b0;
    regAddr <= ~a;
    regWdata <= ~d;
  endtask
  task automatic rd(input logic [11:0] a, output logic [7:0] d, output logic ok);
    ok = 1'b0;
    @(posedge clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    regAddr <= ~a;
    for (int n = 0; n < 4 && !ok; n++)
    begin
      #1;
      if (regRvalid === 1'b1)
      begin
        d = regRdata;
        ok = 1'b1;
      end
      else
        @(posedge clk);
    end
  endtask
endmodule
`default_nettype wire

/* bench/tb_top.sv */
// Purpose: Self-checking bench for the register bank.
// Assumes: Status inputs change only between reads.
// Notes:   Unmapped and read-only slots are written to prove they are ignored.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk = 0, rst_n = 0, ce = 1, monitorSigZero = 0, monitorSigOne = 0;
  logic [11:0] st = 0;
  wire regWr, regRd, regRvalid, softReset, lsbFirst, addrAscend, serialOutputPinEnable;
  wire chipPowerDown, distPowerDown, firstLoopPowerDown, secondLoopPowerDown, biasPowerDown;
  wire firstLoopRegEnable, secondLoopRegEnable, statusDivZeroEn, statusDivOneEn;
  wire statusPinZero, statusPinZeroOe, statusPinOne, statusPinOneOe;
  wire [11:0] regAddr;
  wire [7:0] regWdata, regRdata, monitorSelZero, monitorSelOne;
  wire [13:0] channelPowerDown, channelRegEnable;
  wire secondLoopFbStat, firstLoopFbStat, oscStat, bothRefMissing, refInputBStat, refInputAStat;
  wire secondLoopLocked, firstLoopLocked, holdoverActive, selectedRef, fastLockBusy, oscCalBusy;
  assign {secondLoopFbStat, firstLoopFbStat, oscStat, bothRefMissing, refInputBStat,
    refInputAStat, secondLoopLocked, firstLoopLocked, holdoverActive, selectedRef,
    fastLockBusy, oscCalBusy} = st;
  wire [4:0] pdv = {biasPowerDown, secondLoopPowerDown, firstLoopPowerDown, distPowerDown,
    chipPowerDown};
  logic [11:0] ad[12] = '{12'h000, 12'h500, 12'h501, 12'h502, 12'h503, 12'h504, 12'h505,
    12'h506, 12'h507, 12'h508, 12'h509, 12'h510};
  logic [7:0] rv[9] = '{8'h00, 8'h10, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00};
  logic [7:0] mk[9] = '{8'hFF, 8'h1F, 8'hFF, 8'h3F, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h0F};
  logic [7:0] m[9];
  logic [7:0] d;
  int failures = 0, tests_run = 0, i;
  psrb_bank uut (.*);
  psrb_host host (.*);
  initial forever #12.5 clk = ~clk;
  task automatic give_verdict;
    if (failures == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chkRd(input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e)
    begin
      failures++;
      $display("unexpected read at %0t: exp %h got %h", $time, e, g);
    end
  endtask
  task automatic chkOut(input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e)
    begin
      failures++;
      $display("unexpected output at %0t: exp %h got %h", $time, e, g);
    end
  endtask
  function automatic logic [7:0] expRd(input int k);
    if (k < 9)
      return m[k];
    if (k == 9)
      return st[11:4];
    return (k == 10) ? {4'h0, st[3:0]} : 8'h00;
  endfunction
  task automatic readChk(input int k);
    logic [7:0] g;
    logic ok;
    host.rd(ad[k], g, ok);
    if (!ok)
    begin
      failures++;
      give_verdict;
    end
    chkRd(expRd(k), g);
  endtask
  task automatic outs;
    logic [3:0] p;
    p = m[0][7:4] & {m[0][0], m[0][1], m[0][2], m[0][3]};
    chkOut(p, {softReset, lsbFirst, addrAscend, serialOutputPinEnable});
    chkOut(m[1][4:0], pdv);
    chkOut({m[3][5:0], m[2]}, channelPowerDown);
    chkOut({m[5], m[4]}, {secondLoopRegEnable, firstLoopRegEnable, channelRegEnable});
    chkOut({m[7], m[6]}, {monitorSelOne, monitorSelZero});
    chkOut(m[8][3:0], {statusPinOneOe, statusPinZeroOe, statusDivZeroEn, statusDivOneEn});
    chkOut({m[8][3] & monitorSigOne, m[8][2] & monitorSigZero}, {statusPinOne, statusPinZero});
  endtask
  initial
  begin
    void'($urandom(44305));
    m = rv;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    outs();
    for (i = 0; i < 12; i++)
      readChk(i);
    repeat (80)
    begin
      i = $urandom_range(11);
      d = 8'($urandom);
      host.wr(ad[i], d);
      if (i < 9)
        m[i] = d & mk[i];
      st <= 12'($urandom);
      {monitorSigZero, monitorSigOne} <= 2'($urandom);
      repeat (3) @(posedge clk);
      readChk(i);
      outs();
    end
    @(posedge clk);
    ce <= 1'b0;
    host.wr(ad[2], ~m[2]);
    ce <= 1'b1;
    readChk(2);
    outs();
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    m = rv;
    outs();
    for (i = 0; i < 12; i++)
      readChk(i);
    give_verdict;
  end
endmodule
`default_nettype wire

/* design/psrb_bank.v */
// Purpose: Power-down, regulator, status pin and readback register bank.
// Assumes: Serial port logic presents one register access per cycle, same clock.
// Notes:   Read data is registered one cycle after the read strobe.
`timescale 1ns/1ps
`default_nettype none
`include "psrb_defines.vh"
module psrb_bank (
  input  wire        clk,
  input  wire        rst_n,
  input  wire        ce,
  input  wire [11:0] regAddr,
  input  wire        regWr,
  input  wire        regRd,
  input  wire [7:0]  regWdata,
  output reg  [7:0]  regRdata,
  output reg         regRvalid,
  output reg         softReset,
  output reg         lsbFirst,
  output reg         addrAscend,
  output reg         serialOutputPinEnable,
  output reg         chipPowerDown,
  output reg         distPowerDown,
  output reg         firstLoopPowerDown,
  output reg         secondLoopPowerDown,
  output reg         biasPowerDown,
  output reg  [13:0] channelPowerDown,
  output reg  [13:0] channelRegEnable,
  output reg         firstLoopRegEnable,
  output reg         secondLoopRegEnable,
  output reg  [7:0]  monitorSelZero,
  output reg  [7:0]  monitorSelOne,
  output reg         statusDivZeroEn,
  output reg         statusDivOneEn,
  input  wire        monitorSigZero,
  input  wire        monitorSigOne,
  output reg         statusPinZero,
  output reg         statusPinZeroOe,
  output reg         statusPinOne,
  output reg         statusPinOneOe,
  input  wire        secondLoopFbStat,
  input  wire        firstLoopFbStat,
  input  wire        oscStat,
  input  wire        bothRefMissing,
  input  wire        refInputBStat,
  input  wire        refInputAStat,
  input  wire        secondLoopLocked,
  input  wire        firstLoopLocked,
  input  wire        holdoverActive,
  input  wire        selectedRef,
  input  wire        fastLockBusy,
  input  wire        oscCalBusy
);
  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  reg [7:0] cfg_r;
  reg [7:0] pd_r;
  reg [7:0] chpdLo_r;
  reg [7:0] chpdHi_r;
  reg [7:0] ldoLo_r;
  reg [7:0] ldoHi_r;
  reg [7:0] mon0_r;
  reg [7:0] mon1_r;
  reg [7:0] pinCtl_r;
  reg [7:0] rdNxt;
  wire [11:0] stSync;
  wire [7:0]  rb0;
  wire [3:0]  rb1;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // A mirrored control only acts when both copies are one, so a single
  // stray bit flip on the serial port cannot switch on a cleared control.
  function pairAnd;
    input [7:0] cfg;
    input integer hiPos;
    input integer loPos;
    begin
      pairAnd = cfg[hiPos] & cfg[loPos];
    end
  endfunction

  // Channels 8 to 13 sit in the low six bits of the upper register.
  function [13:0] chanField;
    input [7:0] hiReg;
    input [7:0] loReg;
    begin
      chanField = {hiReg[5:0], loReg};
    end
  endfunction

  // Status inputs come from analog and other clock domains.
  psrb_sync2 #(.W(12)) uSync (
    .clk   (clk),
    .rst_n (rst_n),
    .ce    (ce),
    .din   ({secondLoopFbStat, firstLoopFbStat, oscStat, bothRefMissing,
             refInputBStat, refInputAStat, secondLoopLocked, firstLoopLocked,
             holdoverActive, selectedRef, fastLockBusy, oscCalBusy}),
    .dout  (stSync)
  );
  assign rb0 = stSync[11:4]; // RL8
  assign rb1 = stSync[3:0]; // RL9

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  // The soft reset pair is kept as written; the device reset decoder
  // outside clears it, so software sees exactly what it wrote.
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      cfg_r    <= `PSRB_RST_CFG;
      pd_r     <= `PSRB_RST_PD; // RL10
      chpdLo_r <= `PSRB_RST_CHPD; // RL5
      chpdHi_r <= `PSRB_RST_CHPD; // RL5
      ldoLo_r  <= `PSRB_RST_LDO; // RL11
      ldoHi_r  <= `PSRB_RST_LDO; // RL11
      mon0_r   <= `PSRB_RST_MON;
      mon1_r   <= `PSRB_RST_MON;
      pinCtl_r <= `PSRB_RST_PINCTL; // RL6
    end
    else if (ce && regWr)
    begin
      case (regAddr)
        `PSRB_ADDR_CFG:     cfg_r    <= regWdata;
        `PSRB_ADDR_PD:      pd_r     <= {3'h0, regWdata[4:0]};
        `PSRB_ADDR_CHPD_LO: chpdLo_r <= regWdata;
        `PSRB_ADDR_CHPD_HI: chpdHi_r <= {2'h0, regWdata[5:0]};
        `PSRB_ADDR_LDO_LO:  ldoLo_r  <= regWdata;
        `PSRB_ADDR_LDO_HI:  ldoHi_r  <= regWdata;
        `PSRB_ADDR_MON0:    mon0_r   <= regWdata;
        `PSRB_ADDR_MON1:    mon1_r   <= regWdata;
        `PSRB_ADDR_PINCTL:  pinCtl_r <= {4'h0, regWdata[3:0]};
        default:            cfg_r    <= cfg_r;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Readback
  // ----------------------------------------------------------------
  // Unmapped and reserved addresses read as zero.
  always @*
  begin
    case (regAddr)
      `PSRB_ADDR_CFG:     rdNxt = cfg_r;
      `PSRB_ADDR_PD:      rdNxt = pd_r;
      `PSRB_ADDR_CHPD_LO: rdNxt = chpdLo_r;
      `PSRB_ADDR_CHPD_HI: rdNxt = chpdHi_r;
      `PSRB_ADDR_LDO_LO:  rdNxt = ldoLo_r;
      `PSRB_ADDR_LDO_HI:  rdNxt = ldoHi_r;
      `PSRB_ADDR_MON0:    rdNxt = mon0_r;
      `PSRB_ADDR_MON1:    rdNxt = mon1_r;
      `PSRB_ADDR_PINCTL:  rdNxt = pinCtl_r;
      `PSRB_ADDR_RB0:     rdNxt = rb0; // RL8
      `PSRB_ADDR_RB1:     rdNxt = {4'h0, rb1}; // RL9
      default:            rdNxt = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      regRdata              <= 8'h00;
      regRvalid             <= 1'b0;
      softReset             <= 1'b0;
      lsbFirst              <= 1'b0;
      addrAscend            <= 1'b0;
      serialOutputPinEnable <= 1'b0;
      chipPowerDown         <= 1'b0;
      distPowerDown         <= 1'b0;
      firstLoopPowerDown    <= 1'b0;
      secondLoopPowerDown   <= 1'b0;
      biasPowerDown         <= 1'b1;
      channelPowerDown      <= 14'h0000;
      channelRegEnable      <= 14'h3FFF;
      firstLoopRegEnable    <= 1'b1;
      secondLoopRegEnable   <= 1'b1;
      monitorSelZero        <= 8'h00;
      monitorSelOne         <= 8'h00;
      statusDivZeroEn       <= 1'b0;
      statusDivOneEn        <= 1'b0;
      statusPinZero         <= 1'b0;
      statusPinZeroOe       <= 1'b0;
      statusPinOne          <= 1'b0;
      statusPinOneOe        <= 1'b0;
    end
    else if (ce)
    begin
      regRvalid <= regRd;
      if (regRd)
        regRdata <= rdNxt;
      softReset  <= pairAnd(cfg_r, `PSRB_CFG_RESET_HI, `PSRB_CFG_RESET_LO); // RL1
      lsbFirst   <= pairAnd(cfg_r, `PSRB_CFG_LSB_HI, `PSRB_CFG_LSB_LO); // RL2
      addrAscend <= pairAnd(cfg_r, `PSRB_CFG_ASC_HI, `PSRB_CFG_ASC_LO); // RL3
      serialOutputPinEnable <= pairAnd(cfg_r, `PSRB_CFG_OUTEN_HI, `PSRB_CFG_OUTEN_LO); // RL4
      chipPowerDown       <= pd_r[`PSRB_PD_CHIP]; // RL10
      distPowerDown       <= pd_r[`PSRB_PD_DIST]; // RL10
      firstLoopPowerDown  <= pd_r[`PSRB_PD_LOOP1]; // RL10
      secondLoopPowerDown <= pd_r[`PSRB_PD_LOOP2]; // RL10
      biasPowerDown       <= pd_r[`PSRB_PD_BIAS]; // RL10
      channelPowerDown    <= chanField(chpdHi_r, chpdLo_r); // RL5
      channelRegEnable    <= chanField(ldoHi_r, ldoLo_r); // RL11
      firstLoopRegEnable  <= ldoHi_r[6]; // RL11
      secondLoopRegEnable <= ldoHi_r[7]; // RL11
      monitorSelZero      <= mon0_r; // RL7
      monitorSelOne       <= mon1_r; // RL7
      statusDivZeroEn     <= pinCtl_r[`PSRB_PIN_DIV0]; // RL6
      statusDivOneEn      <= pinCtl_r[`PSRB_PIN_DIV1]; // RL6
      // A disabled pin also drives a low level internally so nothing toggles.
      statusPinZeroOe     <= pinCtl_r[`PSRB_PIN_OE0]; // RL6
      statusPinOneOe      <= pinCtl_r[`PSRB_PIN_OE1]; // RL6
      statusPinZero       <= pinCtl_r[`PSRB_PIN_OE0] & monitorSigZero; // RL7
      statusPinOne        <= pinCtl_r[`PSRB_PIN_OE1] & monitorSigOne; // RL7
    end
  end
endmodule
`default_nettype wire

/* design/psrb_defines.vh */
// Purpose: Constants for the power and status register bank.
// Assumes: Registers reached by a plain address/data port from the serial port logic.
// Notes:   Offsets are byte addresses on the serial control port.
// Operation
// [RL1] Soft reset needs both mirrored bits set.
// [RL2] LSB-first only when both order bits set.
// [RL3] Ascending addresses only when both bits set.
// [RL4] Serial output pin enabled only when both set.
// [RL5] Channel power-down bits, zero at reset.
// [RL6] Status pin drive and divider enables.
// [RL7] Two monitor selects route status pins.
// [RL8] Lock and reference status read-only.
// [RL9] Holdover, reference, fast lock, calibration readback.
// [RL10] Chip, distribution, loop, bias power-down bits.
// [RL11] Regulator enables reset to one.
`ifndef PSRB_DEFINES_VH
`define PSRB_DEFINES_VH
`define PSRB_ADDR_CFG      12'h000
`define PSRB_ADDR_PD       12'h500
`define PSRB_ADDR_CHPD_LO  12'h501
`define PSRB_ADDR_CHPD_HI  12'h502
`define PSRB_ADDR_LDO_LO   12'h503
`define PSRB_ADDR_LDO_HI   12'h504
`define PSRB_ADDR_MON0     12'h505
`define PSRB_ADDR_MON1     12'h506
`define PSRB_ADDR_PINCTL   12'h507
`define PSRB_ADDR_RB0      12'h508
`define PSRB_ADDR_RB1      12'h509
`define PSRB_RST_CFG       8'h00
`define PSRB_RST_PD        8'h10
`define PSRB_RST_CHPD      8'h00
`define PSRB_RST_LDO       8'hFF
`define PSRB_RST_MON       8'h00
`define PSRB_RST_PINCTL    8'h00
`define PSRB_CFG_RESET_HI  7
`define PSRB_CFG_RESET_LO  0
`define PSRB_CFG_LSB_HI    6
`define PSRB_CFG_LSB_LO    1
`define PSRB_CFG_ASC_HI    5
`define PSRB_CFG_ASC_LO    2
`define PSRB_CFG_OUTEN_HI  4
`define PSRB_CFG_OUTEN_LO  3
`define PSRB_PD_CHIP       0
`define PSRB_PD_DIST       1
`define PSRB_PD_LOOP1      2
`define PSRB_PD_LOOP2      3
`define PSRB_PD_BIAS       4
`define PSRB_PIN_DIV1      0
`define PSRB_PIN_DIV0      1
`define PSRB_PIN_OE0       2
`define PSRB_PIN_OE1       3
`endif

/* design/psrb_sync2.v */
// Purpose: Two-flop synchroniser for a bus of asynchronous status levels.
// Assumes: Inputs are slow levels; each bit may settle independently.
// Notes:   The first stage is read only by the second stage.
`timescale 1ns/1ps
`default_nettype none
module psrb_sync2 #(
  parameter W = 8
) (
  input  wire         clk,
  input  wire         rst_n,
  input  wire         ce,
  input  wire [W-1:0] din,
  output reg  [W-1:0] dout
);
  reg [W-1:0] meta_r;

  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      meta_r <= {W{1'b0}};
      dout   <= {W{1'b0}};
    end
    else if (ce)
    begin
      meta_r <= din;
      dout   <= meta_r;
    end
  end
endmodule
`default_nettype wire
